// file: cftv_regs.vh
// constants for the coolant flow trip voter
// Summary of operation
// - flow trip: two of four divisions plus permissive
// - vote each hot leg on its own
// - flow trip blocked below permissive setpoint
// - bearing trip: same vote per single pump
// - bearing trip blocked below permissive setpoint
// - bearing reactor trip precedes pump trip above permissive setpoint; pump trip still fires alone below it
// - manual cooling actuations reach all four divisions
// - manual isolation actuations reach all four divisions
// - no one-pump-out permissive gates any trip
// - four channels per pump, two-of-four vote
// - permissive asserted when power above setpoint
`ifndef CFTV_REGS_VH
`define CFTV_REGS_VH
`define CFTV_NUM_DIV     4
`define CFTV_NUM_LEGS    2
`define CFTV_NUM_PUMPS   4
`define CFTV_VOTE_MIN    3'h2
`define CFTV_NUM_MANUAL  2
`define CFTV_PUMP_TRIP_DELAY 4'h2
`endif

// file: cftv_sensor_model.sv
// sensor channel model giving per-leg low flow partial trips
`timescale 1ns/100ps
module cftv_sensor_model (input wire sys_clk, input wire [3:0] low0, input wire [3:0] low1,
  output logic [3:0] flow_leg0_part = 4'h0, output logic [3:0] flow_leg1_part = 4'h0);
  // each leg keeps its own elbow measurement, never merged across legs
  always @(posedge sys_clk) begin flow_leg0_part <= low0; flow_leg1_part <= low1; end
endmodule

// file: cftv_trip_voter.v
// coolant flow and pump bearing temperature trip voter with manual actuation fan-out
`timescale 1ns/100ps
`include "cftv_regs.vh"
module cftv_trip_voter #(
  parameter PUMP_DELAY = `CFTV_PUMP_TRIP_DELAY
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // low flow partial trips, one bit per division, per hot leg
  input  wire [3:0] flow_leg0_part,
  input  wire [3:0] flow_leg1_part,
  // bearing temperature partial trips, four channels per pump
  input  wire [15:0] bearing_part,
  // power range permissive partial signals per division
  input  wire [3:0] power_range_permissive_a,
  // manual actuation requests
  input  wire [1:0] manual_cooling,
  input  wire [1:0] manual_isolation,
  // trip outputs
  output reg        flow_trip_q,
  output reg        bearing_trip_q,
  output reg        reactor_trip_q,
  output reg  [3:0] pump_trip_q,
  output reg        permissive_q,
  // manual actuations fanned out, bit [2*div+n]
  output reg  [7:0] div_cooling_q,
  output reg  [7:0] div_isolation_q
);

  // two-stage synchronisers; every input comes from a field channel on its own
  // timing, so only the second stage is ever read by the voting logic
  reg  [3:0]  fl0_s1;
  reg  [3:0]  fl0_s2;
  reg  [3:0]  fl1_s1;
  reg  [3:0]  fl1_s2;
  reg  [3:0]  prm_s1;
  reg  [3:0]  prm_s2;
  reg  [15:0] brg_s1;
  reg  [15:0] brg_s2;
  reg  [1:0]  cool_s1;
  reg  [1:0]  cool_s2;
  reg  [1:0]  iso_s1;
  reg  [1:0]  iso_s2;

  // hot leg 0 low flow partial trips
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fl0_s1 <= 4'h0;
      fl0_s2 <= 4'h0;
    end else begin
      fl0_s1 <= flow_leg0_part;
      fl0_s2 <= fl0_s1;
    end
  end

  // hot leg 1 low flow partial trips, kept apart from leg 0 all the way
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fl1_s1 <= 4'h0;
      fl1_s2 <= 4'h0;
    end else begin
      fl1_s1 <= flow_leg1_part;
      fl1_s2 <= fl1_s1;
    end
  end

  // power range permissive partials, one per division
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prm_s1 <= 4'h0;
      prm_s2 <= 4'h0;
    end else begin
      prm_s1 <= power_range_permissive_a;
      prm_s2 <= prm_s1;
    end
  end

  // bearing temperature partials, sixteen channels in four pump groups
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_s1 <= 16'h0000;
      brg_s2 <= 16'h0000;
    end else begin
      brg_s1 <= bearing_part;
      brg_s2 <= brg_s1;
    end
  end

  // manual containment cooling requests
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cool_s1 <= 2'h0;
      cool_s2 <= 2'h0;
    end else begin
      cool_s1 <= manual_cooling;
      cool_s2 <= cool_s1;
    end
  end

  // manual containment isolation requests
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      iso_s1 <= 2'h0;
      iso_s2 <= 2'h0;
    end else begin
      iso_s1 <= manual_isolation;
      iso_s2 <= iso_s1;
    end
  end

  // per-group vote results
  wire [1:0] leg_vote;
  wire [3:0] pump_vote;
  wire       perm_vote;

  // hot leg 0 voted on its own; a single division on each leg never combines
  cftv_vote u_leg0 (
    .part_trip (fl0_s2),
    .vote_trip (leg_vote[0])
  );

  // hot leg 1 voted on its own
  cftv_vote u_leg1 (
    .part_trip (fl1_s2),
    .vote_trip (leg_vote[1])
  );

  // permissive itself is voted two of four across divisions, so one failed
  // channel can neither block nor arm the trips
  cftv_vote u_perm (
    .part_trip (prm_s2),
    .vote_trip (perm_vote)
  );

  // one voter per pump; channels of different pumps never add up
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_pump
      cftv_vote u_pump (
        .part_trip (brg_s2[4*p+3:4*p]),
        .vote_trip (pump_vote[p])
      );
    end
  endgenerate

  // trips gated only by the power permissive; no one-pump-out permissive exists
  wire flow_d    = (|leg_vote) & perm_vote;
  wire bearing_d = (|pump_vote) & perm_vote;

  // true once a pump vote has persisted for the whole hold-back time
  function pump_expired;
    input [3:0] cnt;
    begin
      pump_expired = (cnt == PUMP_DELAY[3:0]);
    end
  endfunction

  // low flow trip, registered so downstream actuation sees a clean level
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flow_trip_q <= 1'b0;
    end else begin
      flow_trip_q <= flow_d;
    end
  end

  // bearing temperature trip
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bearing_trip_q <= 1'b0;
    end else begin
      bearing_trip_q <= bearing_d;
    end
  end

  // combined reactor trip; built from the same next values so it never lags
  // either of its two sources by a cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reactor_trip_q <= 1'b0;
    end else begin
      reactor_trip_q <= flow_d | bearing_d;
    end
  end

  // voted permissive, shown for monitoring
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      permissive_q <= 1'b0;
    end else begin
      permissive_q <= perm_vote;
    end
  end

  // delay counters hold pump trips back so the reactor trip lands first;
  // the pump trip is not permissive-gated, so it still fires at low power
  reg [3:0] pump_cnt_q [0:3];
  integer i;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_trip_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        pump_cnt_q[i] <= 4'h0;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        // a dropped vote restarts the hold-back from zero
        if (!pump_vote[i]) begin
          pump_cnt_q[i] <= 4'h0;
        end else if (!pump_expired(pump_cnt_q[i])) begin
          pump_cnt_q[i] <= pump_cnt_q[i] + 4'h1;
        end
        pump_trip_q[i] <= pump_vote[i] && pump_expired(pump_cnt_q[i]);
      end
    end
  end

  // every manual cooling actuation reaches all four divisions, including the
  // fourth; containment isolation is driven only by the isolation requests
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cooling_q <= 8'h00;
    end else begin
      div_cooling_q <= {4{cool_s2}};
    end
  end

  // every manual isolation actuation reaches all four divisions
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_isolation_q <= 8'h00;
    end else begin
      div_isolation_q <= {4{iso_s2}};
    end
  end
endmodule

// file: cftv_trip_voter_sva.sv
// checker for the coolant flow trip voter outputs
`timescale 1ns/100ps
module cftv_trip_voter_sva #(parameter PUMP_DELAY = 2) (
  input wire sys_clk, input wire rst_n, input wire [3:0] flow_leg0_part, input wire [3:0] flow_leg1_part,
  input wire [15:0] bearing_part, input wire [3:0] power_range_permissive_a, input wire [1:0] manual_cooling,
  input wire [1:0] manual_isolation, input wire flow_trip_q, input wire bearing_trip_q, input wire reactor_trip_q,
  input wire [3:0] pump_trip_q, input wire permissive_q, input wire [7:0] div_cooling_q, input wire [7:0] div_isolation_q);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // reference votes; the sync path is three edges deep so each output is checked against inputs three back
  wire perm = $countones(power_range_permissive_a) >= 2;
  wire fv = $countones(flow_leg0_part) >= 2 || $countones(flow_leg1_part) >= 2;
  wire bv = $countones(bearing_part[3:0]) >= 2 || $countones(bearing_part[7:4]) >= 2
         || $countones(bearing_part[11:8]) >= 2 || $countones(bearing_part[15:12]) >= 2;
  a_perm_vote: assert property (permissive_q == $past(perm, 3)) else $error("permissive vote wrong");
  a_flow_vote: assert property (flow_trip_q == $past(fv && perm, 3)) else $error("flow trip wrong");
  a_bear_vote: assert property (bearing_trip_q == $past(bv && perm, 3)) else $error("bearing trip wrong");
  a_trip_or: assert property (reactor_trip_q == (flow_trip_q || bearing_trip_q)) else $error("trip merge wrong");
  a_cool_fan: assert property (div_cooling_q == {4{$past(manual_cooling, 3)}}) else $error("cooling fan-out wrong");
  a_iso_fan: assert property (div_isolation_q == {4{$past(manual_isolation, 3)}}) else $error("isolation wrong");
  a_pump_late: assert property ($rose(|pump_trip_q) && $past(permissive_q) |-> $past(reactor_trip_q))
    else $error("pump tripped before reactor");
  a_pump_cause: assert property ($rose(|pump_trip_q) |-> $past(bv, 4)) else $error("pump trip without vote");
endmodule
bind cftv_trip_voter cftv_trip_voter_sva #(.PUMP_DELAY(PUMP_DELAY)) i_sva (.*);

// file: cftv_trip_voter_test.sv
// self-checking bench for the coolant flow trip voter
`timescale 1ns/100ps
module cftv_trip_voter_test;
  logic sys_clk = 1'h0, rst_n = 1'h0, ft, bt, rt, pq;
  logic [3:0] low0 = 4'h0, low1 = 4'h0, pra = 4'h0, pump_q, fl0, fl1;
  logic [15:0] bp = 16'h0;
  logic [1:0] mc = 2'h0, mi = 2'h0;
  logic [7:0] dc, di;
  int bad_count = 0, checked = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  cftv_sensor_model i_cftv_sensor_model (.sys_clk(sys_clk), .low0(low0), .low1(low1), .flow_leg0_part(fl0),
    .flow_leg1_part(fl1));
  cftv_trip_voter i_cftv_trip_voter (.sys_clk(sys_clk), .rst_n(rst_n), .flow_leg0_part(fl0), .flow_leg1_part(fl1),
    .bearing_part(bp), .power_range_permissive_a(pra), .manual_cooling(mc), .manual_isolation(mi), .flow_trip_q(ft),
    .bearing_trip_q(bt), .reactor_trip_q(rt), .pump_trip_q(pump_q), .permissive_q(pq), .div_cooling_q(dc),
    .div_isolation_q(di));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin bad_count++; $display("MISMATCH %s expected %h seen %h", n, e, g); end
  endtask
  // inputs are levels, so hold them long enough for the pump delay to expire too
  task set(input logic [3:0] a, input logic [3:0] b, input logic [3:0] p, input logic [15:0] q);
    @(posedge sys_clk); low0 <= a; low1 <= b; pra <= p; bp <= q;
    repeat (12) @(posedge sys_clk);
  endtask
  task t_flow;
    set(4'h3, 4'h0, 4'hf, 16'h0); chk("flow", 8'h1, ft); chk("reactor", 8'h1, rt);
    set(4'h1, 4'h2, 4'hf, 16'h0); chk("cross leg", 8'h0, ft);
    set(4'h0, 4'hc, 4'h1, 16'h0); chk("blocked", 8'h0, ft);
    set(4'h0, 4'hc, 4'h3, 16'h0); chk("rearmed", 8'h1, ft); chk("permissive", 8'h1, pq);
  endtask
  task t_bear;
    set(4'h0, 4'h0, 4'hf, 16'h0300); chk("bearing", 8'h1, bt); chk("pump", 8'h4, pump_q);
    set(4'h0, 4'h0, 4'h0, 16'h0300); chk("bear blocked", 8'h0, bt);
    set(4'h0, 4'h0, 4'hf, 16'h1111); chk("cross pump", 8'h0, bt);
  endtask
  task t_man;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk); mc <= i[1:0]; mi <= ~i[1:0];
      repeat (6) @(posedge sys_clk);
      chk("cooling", {4{i[1:0]}}, dc); chk("isolation", {4{~i[1:0]}}, di);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatched %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the some 130 cycles the run needs
  always @(posedge sys_clk) begin cyc++; if (cyc == 2000) begin bad_count++; print_verdict; end end
  initial begin repeat (10) @(posedge sys_clk); rst_n <= 1'h1; t_flow; t_bear; t_man; print_verdict; end
endmodule

// file: cftv_vote.v
// two-of-four coincidence voter for one group of division partial trips
`timescale 1ns/100ps
`include "cftv_regs.vh"
module cftv_vote (
  // partial trips of the four divisions in one group
  input  wire [3:0] part_trip,
  // vote result
  output wire       vote_trip
);
  // count agreeing divisions; two or more trips the group
  wire [2:0] count = {2'h0, part_trip[0]} + {2'h0, part_trip[1]} +
                     {2'h0, part_trip[2]} + {2'h0, part_trip[3]};
  assign vote_trip = (count >= `CFTV_VOTE_MIN);
endmodule
